// ---- design/ssc_pkg.sv ----
// Constants for the serializer sideband control block.
// Assumes one system clock at 100 MHz and a byte-wide register port.
package ssc_pkg;
    // ==========================================
    // Sizes
    localparam int PIX_WIDTH = 24;
    localparam int GPIO_N = 4;
    localparam int FAULT_N = 6;
    localparam int AUD_N = 3;
    // ==========================================
    // Register offsets
    localparam logic [7:0] ADDR_ALT_RATE = 8'h04;
    localparam logic [7:0] ADDR_LINK_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_PIN0_CFG = 8'h0d;
    localparam logic [7:0] ADDR_PIN12_CFG = 8'h0e;
    localparam logic [7:0] ADDR_PIN3_OUT4_CFG = 8'h0f;
    localparam logic [7:0] ADDR_OUT56_CFG = 8'h10;
    localparam logic [7:0] ADDR_OUT7_CFG = 8'h11;
    localparam logic [7:0] ADDR_DEPTH_CFG = 8'h12;
    localparam logic [7:0] ADDR_PIXEL_CFG = 8'h13;
    localparam logic [7:0] ADDR_RATE_OVR = 8'h35;
    localparam logic [7:0] ADDR_IRQ_CONTROL = 8'hc6;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hc7;
    // ==========================================
    // Field positions
    localparam int ALT_OVR_EN_BIT = 1;
    localparam int ALT_OVR_VAL_BIT = 0;
    localparam int RATE_OVR_EN_BIT = 7;
    localparam int RATE_OVR_VAL_BIT = 6;
    localparam int LINK_DETECT_BIT = 0;
    localparam int MODE18_BIT = 2;
    localparam int IRQ_ROUTE_BIT = 5;
    localparam int IRQ_EN_BIT = 0;
    localparam int ISR_ANY_BIT = 0;
    localparam int ISR_REMOTE_BIT = 5;
    localparam int EDGE_SEL_BIT = 0;
    localparam int PAT_EN_BIT = 1;
    localparam int AUD_ACTIVE_BIT = 2;
    localparam int OSC_DIV_LSB = 4;
    localparam int OUT_EN_BIT = 0;
    localparam int OUT_IN_BIT = 1;
    localparam int OUT_VAL_BIT = 3;
    localparam logic [3:0] CODE_FWD_IN = 4'h3;
    localparam logic [3:0] CODE_BACK_OUT = 4'h5;
    // ==========================================
    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] PIXEL_CFG_RESET = 8'h01;
    // ==========================================
    // Timing
    localparam int SYS_CLK_MHZ = 100;
    localparam int PCLK_LOSS_NS = 1000;
    localparam int PCLK_LOSS_CYC = (PCLK_LOSS_NS * SYS_CLK_MHZ + 999) / 1000;
endpackage

// ---- design/ssc_sync2.sv ----
// Two flip-flop level synchroniser, one bit per lane.
// Assumes each lane is an independent level; no word coherence.
module ssc_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset of the receiving domain
    input wire logic clk,
    input wire logic rst,
    // Lanes
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= RESET_VAL;
            q <= RESET_VAL;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ---- design/ssc_sideband_ctrl.sv ----
// Sideband control: link status, pixel capture, rate decode,
// interrupts, general pins, local outputs and audio carriage.
// Assumes a byte register port on sys_clk and a link port on linkClk.
module ssc_sideband_ctrl #(
    parameter int LOSS_CYC = ssc_pkg::PCLK_LOSS_CYC
) (
    // Clocks and resets
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic linkRst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata_r,
    // Pixel and control pins
    input wire logic pclkPin,
    input wire logic [ssc_pkg::PIX_WIDTH-1:0] pixelPin,
    input wire logic dataEnablePin,
    input wire logic powerDownN,
    input wire logic rateSelectPin,
    input wire logic modeSelAltPin,
    input wire logic [ssc_pkg::FAULT_N-1:0] faultPin,
    input wire logic [ssc_pkg::AUD_N-1:0] audioPin,
    // Captured pixel stream
    output logic [ssc_pkg::PIX_WIDTH-1:0] pixelOut_r,
    output logic pixelStrobe_r,
    // Rate mode
    output logic highRateMode_r,
    output logic midRateMode_r,
    output logic lowRateMode_r,
    // Interrupt pins
    output logic remoteIrqMirrorN_r,
    output logic localIrqN_r,
    // General pins on R[1:0], G[1:0]; input side is pixelPin
    output logic [ssc_pkg::GPIO_N-1:0] gpioOut_r,
    output logic [ssc_pkg::GPIO_N-1:0] gpioOeN_r,
    // Local output pins 4..7 (index 0 is pin 4)
    input wire logic [3:0] localOutIn,
    output logic [3:0] localOut_r,
    output logic [3:0] localOutOeN_r,
    // Back channel, linkClk domain
    input wire logic bcLock,
    input wire logic bcFarIrqN,
    input wire logic [ssc_pkg::GPIO_N-1:0] bcGpio,
    // Forward channel, linkClk domain
    output logic [ssc_pkg::GPIO_N-1:0] fwdGpio_r,
    output logic fwdMode18_r,
    output logic [ssc_pkg::AUD_N-1:0] fwdAudio_r
);
    import ssc_pkg::*;

    // Counter is 16 bits wide and needs at least two idle cycles
    if (LOSS_CYC < 2 || LOSS_CYC > 65535)
    begin : g_lossCheck
        $error("LOSS_CYC out of range");
    end

    // ==========================================
    // Pin synchronisers
    localparam int PIN_W = PIX_WIDTH + FAULT_N + AUD_N + 9;
    logic [PIN_W-1:0] pinSync;
    logic [PIX_WIDTH-1:0] pixSync;
    logic [FAULT_N-1:0] faultSync;
    logic [AUD_N-1:0] audSync;
    logic [3:0] outInSync;
    logic pclkSync, deSync, pwrSync, rateSync, altSync;

    ssc_sync2 #(.WIDTH(PIN_W)) u_pinSync (
        .clk(sys_clk),
        .rst(rst),
        .d({pixelPin, faultPin, audioPin, localOutIn, pclkPin,
            dataEnablePin, powerDownN, rateSelectPin, modeSelAltPin}),
        .q(pinSync)
    );
    assign {pixSync, faultSync, audSync, outInSync, pclkSync,
            deSync, pwrSync, rateSync, altSync} = pinSync;

    // ==========================================
    // Link domain: back channel capture
    logic bcLock_r, bcFarIrqN_r;
    logic [GPIO_N-1:0] bcGpio_r;

    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            bcLock_r <= 1'b0;
            bcFarIrqN_r <= 1'b1;
            bcGpio_r <= '0;
        end
        else
        begin
            bcLock_r <= bcLock;
            bcFarIrqN_r <= bcFarIrqN;
            bcGpio_r <= bcGpio;
        end
    end

    // Remote state only used after crossing
    logic lockSync, farIrqSync;
    logic [GPIO_N-1:0] bcGpioSync;

    ssc_sync2 #(.WIDTH(GPIO_N + 2), .RESET_VAL(6'h01)) u_bcSync (
        .clk(sys_clk),
        .rst(rst),
        .d({bcGpio_r, bcLock_r, bcFarIrqN_r}),
        .q({bcGpioSync, lockSync, farIrqSync})
    );

    // ==========================================
    // Register file
    logic [7:0] altRate_r, pin0Cfg_r, pin12Cfg_r, pin3o4Cfg_r;
    logic [7:0] o56Cfg_r, o7Cfg_r, depthCfg_r, pixCfg_r, rateOvr_r, icr_r;
    logic [7:0] altRate_nxt, pin0Cfg_nxt, pin12Cfg_nxt, pin3o4Cfg_nxt;
    logic [7:0] o56Cfg_nxt, o7Cfg_nxt, depthCfg_nxt, pixCfg_nxt, rateOvr_nxt, icr_nxt;
    logic [7:0] regRdata_nxt;
    logic linkDetect_r, pending_r;

    always_comb
    begin
        altRate_nxt = altRate_r;
        pin0Cfg_nxt = pin0Cfg_r;
        pin12Cfg_nxt = pin12Cfg_r;
        pin3o4Cfg_nxt = pin3o4Cfg_r;
        o56Cfg_nxt = o56Cfg_r;
        o7Cfg_nxt = o7Cfg_r;
        depthCfg_nxt = depthCfg_r;
        pixCfg_nxt = pixCfg_r;
        rateOvr_nxt = rateOvr_r;
        icr_nxt = icr_r;
        if (regWrite)
        begin
            case (regAddr)
                ADDR_ALT_RATE: altRate_nxt = regWdata;
                ADDR_PIN0_CFG: pin0Cfg_nxt = regWdata;
                ADDR_PIN12_CFG: pin12Cfg_nxt = regWdata;
                ADDR_PIN3_OUT4_CFG: pin3o4Cfg_nxt = regWdata;
                ADDR_OUT56_CFG: o56Cfg_nxt = regWdata;
                ADDR_OUT7_CFG: o7Cfg_nxt = regWdata;
                ADDR_DEPTH_CFG: depthCfg_nxt = regWdata;
                ADDR_PIXEL_CFG: pixCfg_nxt = regWdata;
                ADDR_RATE_OVR: rateOvr_nxt = regWdata;
                ADDR_IRQ_CONTROL: icr_nxt = regWdata;
                default: ;
            endcase
        end
        regRdata_nxt = regRdata_r;
        if (regRead)
        begin
            case (regAddr)
                ADDR_ALT_RATE: regRdata_nxt = altRate_r;
                ADDR_LINK_STATUS: regRdata_nxt = {7'h00, linkDetect_r};
                ADDR_PIN0_CFG: regRdata_nxt = pin0Cfg_r;
                ADDR_PIN12_CFG: regRdata_nxt = pin12Cfg_r;
                ADDR_PIN3_OUT4_CFG: regRdata_nxt = pin3o4Cfg_r;
                ADDR_OUT56_CFG: regRdata_nxt = o56Cfg_r;
                ADDR_OUT7_CFG: regRdata_nxt = o7Cfg_r;
                ADDR_DEPTH_CFG: regRdata_nxt = depthCfg_r;
                ADDR_PIXEL_CFG: regRdata_nxt = pixCfg_r;
                ADDR_RATE_OVR: regRdata_nxt = rateOvr_r;
                ADDR_IRQ_CONTROL: regRdata_nxt = icr_r;
                ADDR_IRQ_STATUS: regRdata_nxt = {2'h0, pending_r, 4'h0, pending_r};
                default: regRdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            altRate_r <= CFG_RESET;
            pin0Cfg_r <= CFG_RESET;
            pin12Cfg_r <= CFG_RESET;
            pin3o4Cfg_r <= CFG_RESET;
            o56Cfg_r <= CFG_RESET;
            o7Cfg_r <= CFG_RESET;
            depthCfg_r <= CFG_RESET;
            pixCfg_r <= PIXEL_CFG_RESET;
            rateOvr_r <= CFG_RESET;
            icr_r <= CFG_RESET;
            regRdata_r <= 8'h00;
        end
        else
        begin
            altRate_r <= altRate_nxt;
            pin0Cfg_r <= pin0Cfg_nxt;
            pin12Cfg_r <= pin12Cfg_nxt;
            pin3o4Cfg_r <= pin3o4Cfg_nxt;
            o56Cfg_r <= o56Cfg_nxt;
            o7Cfg_r <= o7Cfg_nxt;
            depthCfg_r <= depthCfg_nxt;
            pixCfg_r <= pixCfg_nxt;
            rateOvr_r <= rateOvr_nxt;
            icr_r <= icr_nxt;
            regRdata_r <= regRdata_nxt;
        end
    end

    // ==========================================
    // Link status, rate decode, interrupts
    logic mode18, rateSel, altSel, farIrqD_r, isrRead, irqSet;
    logic linkDetect_nxt, pending_nxt, mirror_nxt, high_nxt, mid_nxt, low_nxt;

    assign mode18 = depthCfg_r[MODE18_BIT];
    assign rateSel = rateOvr_r[RATE_OVR_EN_BIT] ? rateOvr_r[RATE_OVR_VAL_BIT] : rateSync;
    assign altSel = altRate_r[ALT_OVR_EN_BIT] ? altRate_r[ALT_OVR_VAL_BIT] : altSync;
    assign isrRead = regRead && (regAddr == ADDR_IRQ_STATUS);
    // Masked unless both routing and enable bits are set
    assign irqSet = icr_r[IRQ_ROUTE_BIT] && icr_r[IRQ_EN_BIT] && farIrqD_r && !farIrqSync;

    always_comb
    begin
        linkDetect_nxt = !(|faultSync);
        high_nxt = !altSel;
        mid_nxt = rateSel && altSel;
        low_nxt = !rateSel && altSel;
        // New event wins over a clearing read
        pending_nxt = irqSet || (pending_r && !isrRead);
        mirror_nxt = lockSync ? farIrqSync : 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            linkDetect_r <= 1'b0;
            highRateMode_r <= 1'b1;
            midRateMode_r <= 1'b0;
            lowRateMode_r <= 1'b0;
            pending_r <= 1'b0;
            localIrqN_r <= 1'b1;
            remoteIrqMirrorN_r <= 1'b0;
            farIrqD_r <= 1'b1;
        end
        else
        begin
            linkDetect_r <= linkDetect_nxt;
            highRateMode_r <= high_nxt;
            midRateMode_r <= mid_nxt;
            lowRateMode_r <= low_nxt;
            pending_r <= pending_nxt;
            localIrqN_r <= !pending_nxt;
            remoteIrqMirrorN_r <= mirror_nxt;
            farIrqD_r <= farIrqSync;
        end
    end

    // ==========================================
    // Pixel capture and test pattern
    // Pixel clock is oversampled; it must stay well below sys_clk/2.
    logic pclkD_r, capture, patOn, pclkLost, patTick;
    logic [15:0] lossCnt_r, lossCnt_nxt;
    logic [3:0] oscCnt_r, oscCnt_nxt;
    logic [7:0] patCnt_r, patCnt_nxt;
    logic [PIX_WIDTH-1:0] pixel_nxt, pixMasked;
    logic strobe_nxt;

    assign capture = pixCfg_r[EDGE_SEL_BIT] ? (pclkSync && !pclkD_r) : (!pclkSync && pclkD_r);
    assign pclkLost = (lossCnt_r == 16'(LOSS_CYC));
    assign patOn = pixCfg_r[PAT_EN_BIT] && pwrSync;
    // Without a pixel clock the pattern steps on a divided oscillator
    assign patTick = pclkLost ? (oscCnt_r == pixCfg_r[7:OSC_DIV_LSB]) : capture;

    always_comb
    begin
        pixMasked = pixSync;
        if (mode18)
        begin
            pixMasked[17:16] = 2'h0;
            pixMasked[9:8] = 2'h0;
        end
        lossCnt_nxt = capture ? 16'h0000 : (pclkLost ? lossCnt_r : lossCnt_r + 16'h0001);
        oscCnt_nxt = (!pclkLost || patTick) ? 4'h0 : oscCnt_r + 4'h1;
        patCnt_nxt = (patOn && patTick) ? patCnt_r + 8'h01 : patCnt_r;
        pixel_nxt = pixelOut_r;
        strobe_nxt = 1'b0;
        if (patOn)
        begin
            strobe_nxt = patTick;
            if (patTick)
                pixel_nxt = {patCnt_r, ~patCnt_r, patCnt_r ^ 8'h55};
        end
        else if (pwrSync && capture)
        begin
            strobe_nxt = 1'b1;
            pixel_nxt = pixMasked;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pclkD_r <= 1'b0;
            lossCnt_r <= 16'h0000;
            oscCnt_r <= 4'h0;
            patCnt_r <= 8'h00;
            pixelOut_r <= '0;
            pixelStrobe_r <= 1'b0;
        end
        else
        begin
            pclkD_r <= pclkSync;
            lossCnt_r <= lossCnt_nxt;
            oscCnt_r <= oscCnt_nxt;
            patCnt_r <= patCnt_nxt;
            pixelOut_r <= pixel_nxt;
            pixelStrobe_r <= strobe_nxt;
        end
    end

    // ==========================================
    // General pins, local outputs, audio
    logic [3:0] pinCode [GPIO_N];
    logic [GPIO_N-1:0] gpioPinIn, gpioOut_nxt, gpioOeN_nxt, fwdGpioSys_nxt;
    logic [3:0] outNib [4];
    logic [3:0] localOut_nxt, localOutOeN_nxt;
    logic [AUD_N-1:0] fwdAudioSys_nxt;
    logic [GPIO_N-1:0] fwdGpioSys_r;
    logic [AUD_N-1:0] fwdAudioSys_r;

    assign pinCode[0] = pin0Cfg_r[3:0];
    assign pinCode[1] = pin12Cfg_r[3:0];
    assign pinCode[2] = pin12Cfg_r[7:4];
    assign pinCode[3] = pin3o4Cfg_r[3:0];
    assign outNib[0] = pin3o4Cfg_r[7:4];
    assign outNib[1] = o56Cfg_r[3:0];
    assign outNib[2] = o56Cfg_r[7:4];
    assign outNib[3] = o7Cfg_r[3:0];
    assign gpioPinIn = {pixSync[9:8], pixSync[17:16]};

    always_comb
    begin
        for (int i = 0; i < GPIO_N; i++)
        begin
            gpioOut_nxt[i] = 1'b0;
            gpioOeN_nxt[i] = 1'b1;
            fwdGpioSys_nxt[i] = 1'b0;
            if (mode18 && pinCode[i] == CODE_FWD_IN)
                fwdGpioSys_nxt[i] = gpioPinIn[i];
            if (mode18 && pinCode[i] == CODE_BACK_OUT)
            begin
                gpioOut_nxt[i] = bcGpioSync[i];
                gpioOeN_nxt[i] = 1'b0;
            end
        end
        for (int k = 0; k < 4; k++)
        begin
            localOut_nxt[k] = outNib[k][OUT_VAL_BIT];
            localOutOeN_nxt[k] = !outNib[k][OUT_EN_BIT];
            if (k < 2 && outNib[k][OUT_EN_BIT] && outNib[k][OUT_IN_BIT])
            begin
                localOut_nxt[k] = 1'b0;
                localOutOeN_nxt[k] = 1'b1;
                fwdGpioSys_nxt[k] = outInSync[k];
            end
        end
        // Audio only in 24-bit mode, in blanking unless active carriage set
        fwdAudioSys_nxt = '0;
        if (!mode18 && (!deSync || pixCfg_r[AUD_ACTIVE_BIT]))
            fwdAudioSys_nxt = audSync;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            gpioOut_r <= '0;
            gpioOeN_r <= '1;
            localOut_r <= 4'h0;
            localOutOeN_r <= 4'hf;
            fwdGpioSys_r <= '0;
            fwdAudioSys_r <= '0;
        end
        else
        begin
            gpioOut_r <= gpioOut_nxt;
            gpioOeN_r <= gpioOeN_nxt;
            localOut_r <= localOut_nxt;
            localOutOeN_r <= localOutOeN_nxt;
            fwdGpioSys_r <= fwdGpioSys_nxt;
            fwdAudioSys_r <= fwdAudioSys_nxt;
        end
    end

    // ==========================================
    // Link domain: forward channel
    // Lanes cross independently; each is a slow level.
    logic [GPIO_N+AUD_N:0] fwdSync;

    ssc_sync2 #(.WIDTH(GPIO_N + AUD_N + 1)) u_fwdSync (
        .clk(linkClk),
        .rst(linkRst),
        .d({fwdGpioSys_r, fwdAudioSys_r, mode18}),
        .q(fwdSync)
    );

    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            fwdGpio_r <= '0;
            fwdAudio_r <= '0;
            fwdMode18_r <= 1'b0;
        end
        else
        begin
            {fwdGpio_r, fwdAudio_r, fwdMode18_r} <= fwdSync;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_farFall;
        farIrqD_r && !farIrqSync;
    endsequence

    sequence s_routed;
        icr_r[IRQ_ROUTE_BIT] && icr_r[IRQ_EN_BIT];
    endsequence

    a_link_detect: assert property ((|faultSync) |=> !linkDetect_r)
        else $error("fault did not clear link detect");
    a_link_clean: assert property (!(|faultSync) |=> linkDetect_r)
        else $error("link detect low without fault");
    a_edge_capture: assert property (pwrSync && !patOn && capture |=> pixelStrobe_r
        && pixelOut_r == $past(pixMasked))
        else $error("selected edge did not capture pixel");
    a_mode_decode: assert property (##1 (highRateMode_r == !$past(altSel))
        && (lowRateMode_r == ($past(altSel) && !$past(rateSel))))
        else $error("rate mode decode wrong");
    a_mirror_follow: assert property (lockSync |=> remoteIrqMirrorN_r == $past(farIrqSync))
        else $error("mirror does not follow remote");
    a_mirror_lock: assert property (!lockSync |=> !remoteIrqMirrorN_r)
        else $error("mirror high before lock");
    a_irq_raise: assert property ((s_routed and s_farFall) |=> !localIrqN_r ##1 (!localIrqN_r || $past(isrRead)))
        else $error("local interrupt not raised");
    a_isr_clear: assert property (isrRead && !irqSet |=> localIrqN_r)
        else $error("status read did not release interrupt");
    a_irq_masked: assert property (!icr_r[IRQ_ROUTE_BIT] && localIrqN_r |=> localIrqN_r)
        else $error("masked remote interrupt reached local pin");
    a_out7_drive: assert property (o7Cfg_r[3:0] == 4'h9 |=> !localOutOeN_r[3] && localOut_r[3])
        else $error("local output seven not driven high");
    a_gpio_back: assert property (mode18 && pinCode[0] == CODE_BACK_OUT |=> !gpioOeN_r[0]
        && gpioOut_r[0] == $past(bcGpioSync[0]))
        else $error("back channel pin not driven");
endmodule

// ---- dv/ssc_far_model.sv ----
// Stand-in for the remote deserializer on the back channel.
// Assumes the bench sets wanted levels; outputs move on linkClk only.
module ssc_far_model (
    // Link clock
    input wire logic linkClk,
    // Wanted states
    input wire logic lockReq,
    input wire logic irqReq,
    input wire logic [3:0] gpioReq,
    // Back channel
    output logic bcLock = 1'b0,
    output logic bcFarIrqN = 1'b1,
    output logic [3:0] bcGpio = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Registered so changes land on link edges, clear of system edges
    always @(posedge linkClk)
    begin
        bcLock <= lockReq;
        bcFarIrqN <= ~irqReq;
        bcGpio <= gpioReq;
    end
endmodule

// ---- dv/ssc_sideband_ctrl_bench.sv ----
// Self-checking bench for the sideband control block.
// Assumes the far model on the link side and a 2FF pin sampler.
module ssc_sideband_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ssc_pkg::*;
    typedef struct packed {logic [7:0] a, d; logic [3:0] o, oe; logic [2:0] m;} ssc_row_t;
    // ==========================================
    // Stimulus and observed signals
    logic sys_clk = 0, linkClk = 0, rst = 1, linkRst = 1;
    logic regWrite = 0, regRead = 0, pclkPin = 0, dataEnablePin = 0, powerDownN = 1;
    logic lockReq = 0, irqReq = 0, rateSelectPin = 0, modeSelAltPin = 0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, rdData, regRdata_r;
    logic [PIX_WIDTH-1:0] pixelPin = '0, pixelOut_r;
    logic [5:0] faultPin = 6'h00;
    logic [2:0] audioPin = 3'h0, fwdAudio_r;
    logic [3:0] localOutIn = 4'h0, gpioReq = 4'h0, bcGpio, gpioOut_r, gpioOeN_r, localOut_r, localOutOeN_r, fwdGpio_r;
    logic pixelStrobe_r, highRateMode_r, midRateMode_r, lowRateMode_r, remoteIrqMirrorN_r, localIrqN_r;
    logic bcLock, bcFarIrqN, fwdMode18_r;
    int errors = 0, cmp_count = 0;
    ssc_row_t rows [10] = '{
        '{8'h11, 8'h09, 4'h8, 4'h7, 3'h4}, '{8'h11, 8'h01, 4'h0, 4'h7, 3'h4},
        '{8'h10, 8'h90, 4'h4, 4'h3, 3'h4}, '{8'h10, 8'h09, 4'h2, 4'h5, 3'h4},
        '{8'h0f, 8'h90, 4'h3, 4'h4, 3'h4}, '{8'h0f, 8'h10, 4'h2, 4'h4, 3'h4},
        '{8'h35, 8'hc0, 4'h2, 4'h4, 3'h4}, '{8'h04, 8'h03, 4'h2, 4'h4, 3'h2},
        '{8'h35, 8'h80, 4'h2, 4'h4, 3'h1}, '{8'h04, 8'h00, 4'h2, 4'h4, 3'h4}};
    always #5 sys_clk = ~sys_clk;
    // Odd offset keeps link edges clear of system edges
    initial
    begin
        #2.3;
        forever #15 linkClk = ~linkClk;
    end
    ssc_sideband_ctrl #(.LOSS_CYC(20)) ssc_sideband_ctrl_i (.sys_clk(sys_clk), .rst(rst), .linkClk(linkClk),
        .linkRst(linkRst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata_r(regRdata_r), .pclkPin(pclkPin), .pixelPin(pixelPin), .dataEnablePin(dataEnablePin),
        .powerDownN(powerDownN), .rateSelectPin(rateSelectPin), .modeSelAltPin(modeSelAltPin), .faultPin(faultPin),
        .audioPin(audioPin), .pixelOut_r(pixelOut_r), .pixelStrobe_r(pixelStrobe_r),
        .highRateMode_r(highRateMode_r), .midRateMode_r(midRateMode_r), .lowRateMode_r(lowRateMode_r),
        .remoteIrqMirrorN_r(remoteIrqMirrorN_r), .localIrqN_r(localIrqN_r), .gpioOut_r(gpioOut_r),
        .gpioOeN_r(gpioOeN_r), .localOutIn(localOutIn), .localOut_r(localOut_r),
        .localOutOeN_r(localOutOeN_r), .bcLock(bcLock), .bcFarIrqN(bcFarIrqN), .bcGpio(bcGpio),
        .fwdGpio_r(fwdGpio_r), .fwdMode18_r(fwdMode18_r), .fwdAudio_r(fwdAudio_r));
    ssc_far_model ssc_far_model_i (.linkClk(linkClk), .lockReq(lockReq), .irqReq(irqReq),
        .gpioReq(gpioReq), .bcLock(bcLock), .bcFarIrqN(bcFarIrqN), .bcGpio(bcGpio));
    // ==========================================
    // Tasks
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        @(negedge sys_clk);
        rdData = regRdata_r;
    endtask
    // Data set at each pin edge, so edge choice decides what is kept
    task automatic pixSeq(input logic [7:0] cfg);
        wr(ADDR_PIXEL_CFG, cfg);
        @(posedge sys_clk);
        pixelPin <= 24'h0000aa;
        pclkPin <= 1'b1;
        tick(6);
        @(posedge sys_clk);
        pixelPin <= 24'h000055;
        pclkPin <= 1'b0;
        tick(6);
    endtask
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        stop_test();
    end
    // ==========================================
    // Main sequence
    initial
    begin
        int n;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge linkClk);
        linkRst <= 1'b0;
        tick(2);
        chk({highRateMode_r, midRateMode_r, lowRateMode_r, localIrqN_r, remoteIrqMirrorN_r}, 5'b10010);
        rd(ADDR_PIXEL_CFG);
        chk(rdData, PIXEL_CFG_RESET);
        rd(ADDR_IRQ_CONTROL);
        chk(rdData, CFG_RESET);
        rd(8'h55);
        chk(rdData, 8'h00);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            tick(3);
            chk({localOut_r, localOutOeN_r}, {rows[i].o, rows[i].oe});
            chk({highRateMode_r, midRateMode_r, lowRateMode_r}, rows[i].m);
            rd(rows[i].a);
            chk(rdData, rows[i].d);
        end
        // Rate override still forces the select low
        @(posedge sys_clk);
        rateSelectPin <= 1'b1;
        modeSelAltPin <= 1'b1;
        tick(4);
        chk({highRateMode_r, midRateMode_r, lowRateMode_r}, 3'h1);
        wr(ADDR_RATE_OVR, 8'h00);
        tick(3);
        chk({highRateMode_r, midRateMode_r, lowRateMode_r}, 3'h2);
        @(posedge sys_clk);
        modeSelAltPin <= 1'b0;
        tick(4);
        chk({highRateMode_r, midRateMode_r, lowRateMode_r}, 3'h4);
        @(posedge sys_clk);
        lockReq <= 1'b1;
        tick(12);
        chk(remoteIrqMirrorN_r, 1'b1);
        for (int i = 0; i < 7; i++)
        begin
            @(posedge sys_clk);
            faultPin <= (i < 6) ? 6'h01 << i : 6'h00;
            tick(4);
            rd(ADDR_LINK_STATUS);
            chk(rdData[LINK_DETECT_BIT], i == 6);
        end
        wr(ADDR_IRQ_CONTROL, 8'h01);
        @(posedge sys_clk);
        irqReq <= 1'b1;
        tick(12);
        chk({remoteIrqMirrorN_r, localIrqN_r}, 2'b01);
        @(posedge sys_clk);
        irqReq <= 1'b0;
        tick(12);
        rd(ADDR_IRQ_STATUS);
        wr(ADDR_IRQ_CONTROL, 8'h21);
        @(posedge sys_clk);
        irqReq <= 1'b1;
        tick(12);
        chk(localIrqN_r, 1'b0);
        rd(ADDR_IRQ_STATUS);
        chk({rdData, localIrqN_r}, 9'h043);
        @(posedge sys_clk);
        irqReq <= 1'b0;
        tick(12);
        rd(ADDR_IRQ_STATUS);
        chk({rdData, localIrqN_r}, 9'h001);
        pixSeq(8'h01);
        chk(pixelOut_r, 24'h0000aa);
        pixSeq(8'h00);
        chk(pixelOut_r, 24'h000055);
        @(posedge sys_clk);
        powerDownN <= 1'b0;
        pixSeq(8'h01);
        chk(pixelOut_r, 24'h000055);
        @(posedge sys_clk);
        powerDownN <= 1'b1;
        pixSeq(8'h03);
        chk(pixelOut_r, 24'h00ff55);
        // Pixel clock now idle: pattern steps every div+1 cycles
        wr(ADDR_PIXEL_CFG, 8'h33);
        tick(24);
        n = 0;
        repeat (16)
        begin
            if (pixelStrobe_r === 1'b1)
                n++;
            tick(1);
        end
        chk(n, 4);
        wr(ADDR_PIXEL_CFG, 8'h01);
        wr(ADDR_DEPTH_CFG, 8'h04);
        wr(ADDR_PIN3_OUT4_CFG, 8'h03);
        wr(ADDR_PIN0_CFG, 8'h05);
        wr(ADDR_OUT56_CFG, 8'h03);
        @(posedge sys_clk);
        pixelPin <= 24'h000200;
        gpioReq <= 4'h1;
        localOutIn <= 4'h2;
        tick(20);
        chk({fwdMode18_r, fwdGpio_r[3], fwdGpio_r[1]}, 3'b111);
        chk({gpioOut_r[0], gpioOeN_r[0]}, 2'b10);
        wr(ADDR_DEPTH_CFG, 8'h00);
        @(posedge sys_clk);
        audioPin <= 3'b101;
        tick(20);
        chk(fwdAudio_r, 3'b101);
        @(posedge sys_clk);
        dataEnablePin <= 1'b1;
        tick(20);
        chk(fwdAudio_r, 3'b000);
        stop_test();
    end
endmodule
